// ### hdl/port_cfg_defs.svh
// register offsets, reset values and field codes for the port configuration
`ifndef PORT_CFG_DEFS_SVH
`define PORT_CFG_DEFS_SVH
`define PC_OFS_PULLUP 8'h22
`define PC_OFS_OD 8'h23
`define PC_OFS_FN_HI 8'h24
`define PC_OFS_FN_LO 8'h25
`define PC_RST_VAL 8'h00
`define PC_RD_IDLE 8'h00
`define PC_FN_IN 2'h0
`define PC_FN_EXT 2'h1
`define PC_FN_LCD 2'h2
`define PC_FN_OUT 2'h3
`define PC_FN_W 2
`define PC_PINS 8
`endif

// ### hdl/port_cfg_pkg.sv
// types shared by the port configuration modules
package port_cfg_pkg;
  // order gives codes 0..3: input, external memory, lcd segment, output
  typedef enum logic [1:0] {
    FN_INPUT,
    FN_EXT_MEM,
    FN_LCD_SEG,
    FN_OUTPUT
  } pin_func_t;
endpackage

// ### hdl/port_cfg_if.sv
// configuration bundle from the register file to the pin cells
`timescale 1ns/1ps
`default_nettype none
interface port_cfg_if;
  logic [7:0] pullup_en;
  logic [7:0] od_sel;
  logic [15:0] func;
  modport regs (output pullup_en, output od_sel, output func);
  modport cells (input pullup_en, input od_sel, input func);
endinterface
`default_nettype wire

// ### hdl/first_port_pin.sv
// one pin of the first port: driver type and pull-up gating
`timescale 1ns/1ps
`default_nettype none
module first_port_pin #(
  parameter int IDX = 0
) (
  port_cfg_if.cells cfg,
  input wire logic out_mode,
  input wire logic alt_mode,
  input wire logic data,
  input wire logic alt_out,
  input wire logic alt_oe,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pullup_on
);
  logic od;
  assign od = cfg.od_sel[IDX];

  // alternate function wins over output mode
  always_comb begin
    pin_out = 1'b0;
    pin_oe_n = 1'b1;
    if (alt_mode) begin
      pin_out = alt_out;
      pin_oe_n = ~alt_oe;
    end else if (out_mode) begin
      if (od) begin
        pin_out = 1'b0; // low drive or released
        pin_oe_n = data;
      end else begin
        pin_out = data; // push-pull
        pin_oe_n = 1'b0;
      end
    end
  end

  // pull-up forced off for push-pull output or alternate function
  assign pullup_on = cfg.pullup_en[IDX] &
                     ~(alt_mode | (out_mode & ~od));
endmodule
`default_nettype wire

// ### hdl/second_port_pin.sv
// one pin of the second port: function select and lcd routing
`timescale 1ns/1ps
`include "port_cfg_defs.svh"
`default_nettype none
module second_port_pin #(
  parameter int IDX = 0
) (
  port_cfg_if.cells cfg,
  input wire logic data,
  input wire logic ext_out,
  input wire logic ext_oe,
  input wire logic lcd_level,
  output logic pin_out,
  output logic pin_oe_n,
  output logic seg_sel
);
  port_cfg_pkg::pin_func_t fn;
  assign fn = port_cfg_pkg::pin_func_t'(cfg.func[`PC_FN_W*IDX +: `PC_FN_W]);

  // pin driver per function code
  always_comb begin
    pin_out = 1'b0;
    pin_oe_n = 1'b1;
    seg_sel = 1'b0;
    unique case (fn)
      port_cfg_pkg::FN_INPUT: begin
        pin_oe_n = 1'b1;
      end
      port_cfg_pkg::FN_EXT_MEM: begin
        pin_out = ext_out;
        pin_oe_n = ~ext_oe;
      end
      port_cfg_pkg::FN_LCD_SEG: begin
        pin_out = lcd_level; // segment line 52+IDX
        pin_oe_n = 1'b0;
        seg_sel = 1'b1;
      end
      port_cfg_pkg::FN_OUTPUT: begin
        pin_out = data;
        pin_oe_n = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### hdl/port8_port9_pin_config.sv
// pin configuration registers and pin drive for the first and second ports
`timescale 1ns/1ps
`include "port_cfg_defs.svh"
`default_nettype none
module port8_port9_pin_config #(
  parameter int PINS = `PC_PINS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [PINS-1:0] first_port_out_mode,
  input wire logic [PINS-1:0] first_port_alt_mode,
  input wire logic [PINS-1:0] first_port_data,
  input wire logic [PINS-1:0] first_port_alt_out,
  input wire logic [PINS-1:0] first_port_alt_oe,
  output logic [PINS-1:0] first_port_pin_out,
  output logic [PINS-1:0] first_port_pin_oe_n,
  output logic [PINS-1:0] first_port_pullup_on,
  input wire logic [PINS-1:0] second_port_data,
  input wire logic [PINS-1:0] ext_mem_out,
  input wire logic [PINS-1:0] ext_mem_oe,
  input wire logic [PINS-1:0] lcd_segment_line_level,
  input wire logic [PINS-1:0] second_port_pin_in,
  output logic [PINS-1:0] second_port_pin_out,
  output logic [PINS-1:0] second_port_pin_oe_n,
  output logic [PINS-1:0] second_port_in_data,
  output logic [PINS-1:0] lcd_segment_line_sel
);
  port_cfg_if cfg ();

  logic [7:0] pullup_reg, pullup_next;
  logic [7:0] od_reg, od_next;
  logic [7:0] fn_hi_reg, fn_hi_next;
  logic [7:0] fn_lo_reg, fn_lo_next;
  logic [7:0] rdata_reg, rdata_next;

  logic [PINS-1:0] p1_out, p1_oe_n, p1_pull;
  logic [PINS-1:0] p2_out, p2_oe_n, p2_seg;
  logic [PINS-1:0] p1_out_reg, p1_oe_n_reg, p1_pull_reg;
  logic [PINS-1:0] p2_out_reg, p2_oe_n_reg, p2_seg_reg, p2_in_reg;

  // register writes and registered readback
  always_comb begin
    pullup_next = pullup_reg;
    od_next = od_reg;
    fn_hi_next = fn_hi_reg;
    fn_lo_next = fn_lo_reg;
    rdata_next = `PC_RD_IDLE;
    if (reg_wr) begin
      unique case (reg_addr)
        `PC_OFS_PULLUP: pullup_next = reg_wdata;
        `PC_OFS_OD: od_next = reg_wdata;
        `PC_OFS_FN_HI: fn_hi_next = reg_wdata;
        `PC_OFS_FN_LO: fn_lo_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `PC_OFS_PULLUP: rdata_next = pullup_reg;
        `PC_OFS_OD: rdata_next = od_reg;
        `PC_OFS_FN_HI: rdata_next = fn_hi_reg;
        `PC_OFS_FN_LO: rdata_next = fn_lo_reg;
        default: rdata_next = `PC_RD_IDLE; // unmapped reads zero
      endcase
    end
  end

  // all configuration resets to zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pullup_reg <= `PC_RST_VAL;
      od_reg <= `PC_RST_VAL;
      fn_hi_reg <= `PC_RST_VAL;
      fn_lo_reg <= `PC_RST_VAL;
      rdata_reg <= `PC_RD_IDLE;
    end else begin
      pullup_reg <= pullup_next;
      od_reg <= od_next;
      fn_hi_reg <= fn_hi_next;
      fn_lo_reg <= fn_lo_next;
      rdata_reg <= rdata_next;
    end
  end

  // pin n of the second port sits at bits 2n+1:2n
  assign cfg.pullup_en = pullup_reg;
  assign cfg.od_sel = od_reg;
  assign cfg.func = {fn_hi_reg, fn_lo_reg};

  // one cell per pin on each port
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    first_port_pin #(.IDX(i)) u_p1 (
      .cfg(cfg.cells),
      .out_mode(first_port_out_mode[i]),
      .alt_mode(first_port_alt_mode[i]),
      .data(first_port_data[i]),
      .alt_out(first_port_alt_out[i]),
      .alt_oe(first_port_alt_oe[i]),
      .pin_out(p1_out[i]),
      .pin_oe_n(p1_oe_n[i]),
      .pullup_on(p1_pull[i])
    );
    second_port_pin #(.IDX(i)) u_p2 (
      .cfg(cfg.cells),
      .data(second_port_data[i]),
      .ext_out(ext_mem_out[i]),
      .ext_oe(ext_mem_oe[i]),
      .lcd_level(lcd_segment_line_level[i]),
      .pin_out(p2_out[i]),
      .pin_oe_n(p2_oe_n[i]),
      .seg_sel(p2_seg[i])
    );
  end

  // pin outputs registered; drivers released in reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p1_out_reg <= '0;
      p1_oe_n_reg <= '1;
      p1_pull_reg <= '0;
      p2_out_reg <= '0;
      p2_oe_n_reg <= '1;
      p2_seg_reg <= '0;
      p2_in_reg <= '0;
    end else begin
      p1_out_reg <= p1_out;
      p1_oe_n_reg <= p1_oe_n;
      p1_pull_reg <= p1_pull;
      p2_out_reg <= p2_out;
      p2_oe_n_reg <= p2_oe_n;
      p2_seg_reg <= p2_seg;
      p2_in_reg <= second_port_pin_in;
    end
  end

  assign reg_rdata = rdata_reg;
  assign first_port_pin_out = p1_out_reg;
  assign first_port_pin_oe_n = p1_oe_n_reg;
  assign first_port_pullup_on = p1_pull_reg;
  assign second_port_pin_out = p2_out_reg;
  assign second_port_pin_oe_n = p2_oe_n_reg;
  assign second_port_in_data = p2_in_reg;
  assign lcd_segment_line_sel = p2_seg_reg;

  // checks on register effects at the pins
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence wr_pullup_s;
    reg_wr && reg_addr == `PC_OFS_PULLUP && reg_wdata[3];
  endsequence
  sequence pin3_idle_s;
    !first_port_out_mode[3] && !first_port_alt_mode[3];
  endsequence

  pullup_enable_a:
    assert property (wr_pullup_s ##1 pin3_idle_s |=> first_port_pullup_on[3])
    else $error("pull-up not on after enable write");

  pullup_forced_off_a:
    assert property (first_port_alt_mode[0] ||
                     (first_port_out_mode[0] && !od_reg[0])
                     |=> !first_port_pullup_on[0])
    else $error("pull-up not forced off");

  // sampled reset keeps out the release edge, where the flops still reset
  push_pull_a:
    assert property (!sys_rst && first_port_out_mode[1] &&
                     !first_port_alt_mode[1] && !od_reg[1]
                     |=> !first_port_pin_oe_n[1] &&
                     first_port_pin_out[1] == $past(first_port_data[1]))
    else $error("push-pull pin not driving data");

  open_drain_a:
    assert property (!sys_rst && first_port_out_mode[2] &&
                     !first_port_alt_mode[2] && od_reg[2]
                     |=> first_port_pin_oe_n[2] ==
                     $past(first_port_data[2]) && !first_port_pin_out[2])
    else $error("open-drain pin drive wrong");

  func_input_a:
    assert property (fn_lo_reg[3:2] == `PC_FN_IN
                     |=> second_port_pin_oe_n[1] && !lcd_segment_line_sel[1])
    else $error("input pin is driven");

  func_upper_a:
    assert property (reg_wr && reg_addr == `PC_OFS_FN_HI &&
                     reg_wdata[7:6] == `PC_FN_OUT
                     |=> ##1 !second_port_pin_oe_n[7])
    else $error("upper field not steering pin 7");

  func_lower_a:
    assert property (reg_wr && reg_addr == `PC_OFS_FN_LO &&
                     reg_wdata[1:0] == `PC_FN_LCD
                     |=> ##1 lcd_segment_line_sel[0])
    else $error("lower field not steering pin 0");

  lcd_route_a:
    assert property (fn_lo_reg[5:4] == `PC_FN_LCD |=> lcd_segment_line_sel[2]
                     && second_port_pin_out[2] ==
                     $past(lcd_segment_line_level[2]))
    else $error("lcd segment not routed to pin 2");

  read_back_a:
    assert property (reg_rd && reg_addr == `PC_OFS_OD
                     |=> reg_rdata == $past(od_reg))
    else $error("open-drain register readback wrong");

  // register writes land on the next edge
  write_pullup_a:
    assert property (reg_wr && reg_addr == `PC_OFS_PULLUP
                     |=> pullup_reg == $past(reg_wdata))
    else $error("pull-up register write lost");

  write_od_a:
    assert property (reg_wr && reg_addr == `PC_OFS_OD
                     |=> od_reg == $past(reg_wdata))
    else $error("open-drain register write lost");

  write_fn_hi_a:
    assert property (reg_wr && reg_addr == `PC_OFS_FN_HI
                     |=> fn_hi_reg == $past(reg_wdata))
    else $error("upper function register write lost");

  // unmapped writes leave every register alone
  write_unmapped_a:
    assert property (reg_wr && (reg_addr < `PC_OFS_PULLUP ||
                     reg_addr > `PC_OFS_FN_LO) |=> $stable(pullup_reg) &&
                     $stable(od_reg) && $stable(fn_hi_reg) &&
                     $stable(fn_lo_reg))
    else $error("unmapped write changed a register");

  // readback of the pull-up and upper function registers, zero elsewhere and when idle
  read_pullup_a:
    assert property (reg_rd && reg_addr == `PC_OFS_PULLUP
                     |=> reg_rdata == $past(pullup_reg))
    else $error("pull-up register readback wrong");

  read_fn_hi_a:
    assert property (reg_rd && reg_addr == `PC_OFS_FN_HI
                     |=> reg_rdata == $past(fn_hi_reg))
    else $error("upper function register readback wrong");

  read_unmapped_a:
    assert property (reg_rd && (reg_addr < `PC_OFS_PULLUP ||
                     reg_addr > `PC_OFS_FN_LO) |=> reg_rdata == `PC_RD_IDLE)
    else $error("unmapped read not zero");

  read_idle_a:
    assert property (!reg_rd |=> reg_rdata == `PC_RD_IDLE)
    else $error("read data outside the read slot");

  // pull-up bit takes effect for open-drain output and input
  pullup_open_drain_a:
    assert property (!sys_rst && first_port_out_mode[4] &&
                     !first_port_alt_mode[4] && od_reg[4]
                     |=> first_port_pullup_on[4] == $past(pullup_reg[4]))
    else $error("pull-up ignored in open-drain output");

  pullup_input_a:
    assert property (!sys_rst && !first_port_out_mode[5] &&
                     !first_port_alt_mode[5]
                     |=> first_port_pullup_on[5] == $past(pullup_reg[5]))
    else $error("pull-up ignored in input mode");

  // alternate function drives the pin, an idle pin is released
  alt_drive_a:
    assert property (!sys_rst && first_port_alt_mode[6]
                     |=> first_port_pin_out[6] ==
                     $past(first_port_alt_out[6]) &&
                     first_port_pin_oe_n[6] == !$past(first_port_alt_oe[6]))
    else $error("alternate function not driving pin");

  first_idle_a:
    assert property (!sys_rst && !first_port_out_mode[7] &&
                     !first_port_alt_mode[7] |=> first_port_pin_oe_n[7])
    else $error("first-port input pin is driven");

  // open-drain select write, then a low output on pin 2
  sequence wr_od_pin2_s;
    reg_wr && reg_addr == `PC_OFS_OD && reg_wdata[2];
  endsequence
  sequence pin2_low_out_s;
    first_port_out_mode[2] && !first_port_alt_mode[2] &&
    !first_port_data[2];
  endsequence

  od_drive_low_a:
    assert property (wr_od_pin2_s ##1 pin2_low_out_s
                     |=> !first_port_pin_out[2] && !first_port_pin_oe_n[2])
    else $error("open-drain pin not pulled low");

  // second-port functions at the pin
  ext_mem_a:
    assert property (!sys_rst && fn_hi_reg[1:0] == `PC_FN_EXT
                     |=> second_port_pin_out[4] == $past(ext_mem_out[4]) &&
                     second_port_pin_oe_n[4] == !$past(ext_mem_oe[4]))
    else $error("external memory function not on pin 4");

  out_mode_a:
    assert property (!sys_rst && fn_hi_reg[3:2] == `PC_FN_OUT
                     |=> !second_port_pin_oe_n[5] &&
                     second_port_pin_out[5] == $past(second_port_data[5]))
    else $error("output function not on pin 5");

  lcd_only_a:
    assert property (fn_lo_reg[7:6] != `PC_FN_LCD
                     |=> !lcd_segment_line_sel[3])
    else $error("segment select without lcd function");

  // pin levels reach software one edge later
  in_sample_a:
    assert property (!sys_rst
                     |=> second_port_in_data == $past(second_port_pin_in))
    else $error("pin level not sampled");
endmodule
`default_nettype wire

// ### dv/pin_world.sv
// far side of the second port: pin wires with outside drivers
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input wire logic [7:0] drive,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] ext_level,
  output logic [7:0] level
);
  // a released pin shows the outside level, never the last drive
  assign level = (drive & ~oe_n) | (ext_level & oe_n);
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the port pin configuration block
`timescale 1ns/1ps
`include "port_cfg_defs.svh"
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] fo = 8'h00, fa = 8'h00, fd = 8'h00, fao = 8'h00, fae = 8'h00;
  logic [7:0] sd = 8'h00, xo = 8'h00, xe = 8'h00, ll = 8'h00, el = 8'h00;
  logic [7:0] reg_rdata, f_out, f_oen, f_pu, s_pin, s_out, s_oen, s_in, lcd_segment_line;
  logic [7:0] regs [4];
  logic [31:0] lfsr = 32'hF356;
  logic rd_pend = 1'b0;
  logic [7:0] rd_exp = 8'h00;
  int n_mismatch = 0;
  int total_checks = 0;

  always #2 clk = ~clk;

  port8_port9_pin_config u_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_port_out_mode(fo),
    .first_port_alt_mode(fa), .first_port_data(fd),
    .first_port_alt_out(fao), .first_port_alt_oe(fae),
    .first_port_pin_out(f_out), .first_port_pin_oe_n(f_oen),
    .first_port_pullup_on(f_pu), .second_port_data(sd), .ext_mem_out(xo),
    .ext_mem_oe(xe), .lcd_segment_line_level(ll),
    .second_port_pin_in(s_pin), .second_port_pin_out(s_out),
    .second_port_pin_oe_n(s_oen), .second_port_in_data(s_in),
    .lcd_segment_line_sel(lcd_segment_line));
  pin_world u_world (.drive(s_out), .oe_n(s_oen), .ext_level(el),
    .level(s_pin));

  // eight lfsr steps per byte
  function automatic logic [7:0] rnd();
    for (int k = 0; k < 8; k++) begin
      lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
    end
    return lfsr[7:0];
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus cycle; read data are checked in the cycle after the strobe
  task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    #1;
    chk(reg_rdata, rd_pend ? rd_exp : 8'h00);
    rd_pend = r;
    rd_exp = e;
  endtask

  // read back every register plus an unmapped place
  task automatic rd_all();
    for (int k = 0; k < 4; k++) begin
      cyc(1'b0, 1'b1, `PC_OFS_PULLUP + 8'(k), 8'h00, regs[k]);
    end
    cyc(1'b0, 1'b1, 8'h26, 8'h00, 8'h00);
    repeat (3) cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
  endtask

  // expected pin state worked out per pin from the register copies
  task automatic chk_pins();
    logic [7:0] eo, eoe, ep, m, so, soe, sg, sm;
    logic [15:0] fn;
    port_cfg_pkg::pin_func_t c;
    fn = {regs[2], regs[3]};
    for (int n = 0; n < 8; n++) begin
      m[n] = 1'b1;
      if (fa[n]) begin
        {eo[n], eoe[n], ep[n]} = {fao[n], ~fae[n], 1'b0};
      end else if (fo[n]) begin
        eo[n] = fd[n] & ~regs[1][n];
        eoe[n] = fd[n] & regs[1][n];
        ep[n] = regs[0][n] & regs[1][n];
      end else begin
        {eo[n], eoe[n], ep[n], m[n]} = {1'b0, 1'b1, regs[0][n], 1'b0};
      end
      c = port_cfg_pkg::pin_func_t'(fn[2*n +: 2]);
      sg[n] = (c == port_cfg_pkg::FN_LCD_SEG);
      sm[n] = (c != port_cfg_pkg::FN_INPUT);
      case (c)
        port_cfg_pkg::FN_INPUT: {so[n], soe[n]} = {1'b0, 1'b1};
        port_cfg_pkg::FN_EXT_MEM: {so[n], soe[n]} = {xo[n], ~xe[n]};
        port_cfg_pkg::FN_LCD_SEG: {so[n], soe[n]} = {ll[n], 1'b0};
        default: {so[n], soe[n]} = {sd[n], 1'b0};
      endcase
    end
    chk(f_out & m, eo & m);
    chk(f_oen, eoe);
    chk(f_pu, ep);
    chk(s_out & sm, so & sm);
    chk(s_oen, soe);
    chk(lcd_segment_line, sg);
    chk(s_in, (so & ~soe) | (el & soe));
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  // reset values, random configurations with every code, mid-run reset
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    regs = '{default: 8'h00};
    rd_all();
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      {fo, fa, fd, fao, fae} <= {rnd(), rnd() & rnd(), rnd(), rnd(), rnd()};
      {sd, xo, xe, ll, el} <= {rnd(), rnd(), rnd(), rnd(), rnd()};
      for (int k = 0; k < 4; k++) begin
        regs[k] = (i < 4 && k > 1) ? {4{2'(i)}} : rnd();
        cyc(1'b1, 1'b0, `PC_OFS_PULLUP + 8'(k), regs[k], 8'h00);
      end
      cyc(1'b1, 1'b0, i[0] ? 8'h26 : 8'h21, rnd(), 8'h00);
      rd_all();
      chk_pins();
    end
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    regs = '{default: 8'h00};
    rd_all();
    chk_pins();
    test_done();
  end
endmodule
`default_nettype wire
